// >>> tpm_pkg.sv
package tpm_pkg;

    // ********************************************************
    // Register offsets (byte addresses, one word each)
    // ********************************************************
    localparam logic [7:0] OFS_CTL1    = 8'h00;
    localparam logic [7:0] OFS_CTL0    = 8'h04;
    localparam logic [7:0] OFS_RELOAD  = 8'h08;
    localparam logic [7:0] OFS_MATCH   = 8'h0c;
    localparam logic [7:0] OFS_COUNT   = 8'h10;
    localparam logic [7:0] OFS_CAPTURE = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTL1_EN_BIT      = 7;
    localparam int CTL1_POL_BIT     = 6;
    localparam int CTL1_PRE_LSB     = 3;
    localparam int CTL1_MODE_LSB    = 0;
    localparam int CTL0_MODE3_BIT   = 7;
    localparam int STAT_RELOAD_BIT  = 0;
    localparam int STAT_CAPTURE_BIT = 1;
    localparam int STAT_GATE_BIT    = 2;
    localparam int STAT_OUT_BIT     = 3;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0]  CTL1_RESET   = 8'h00;
    localparam logic [7:0]  CTL0_RESET   = 8'h00;
    localparam logic [31:0] RELOAD_RESET = 32'h0000ffff;
    localparam logic [31:0] MATCH_RESET  = 32'h00000000;

    // ********************************************************
    // Operating modes
    // ********************************************************
    typedef enum logic [3:0] {
        MODE_ONE_SHOT    = 4'h0,
        MODE_CONTINUOUS  = 4'h1,
        MODE_COUNTER     = 4'h2,
        MODE_PWM_SINGLE  = 4'h3,
        MODE_CAPTURE     = 4'h4,
        MODE_COMPARE     = 4'h5,
        MODE_GATED       = 4'h6,
        MODE_CAP_CMP     = 4'h7,
        MODE_PWM_DUAL    = 4'h8,
        MODE_CAP_RESTART = 4'h9,
        MODE_CMP_COUNTER = 4'ha,
        MODE_TRIG_ONE    = 4'hb,
        MODE_DEMOD       = 4'hc,
        MODE_RSVD_D      = 4'hd,
        MODE_RSVD_E      = 4'he,
        MODE_RSVD_F      = 4'hf
    } tpm_mode_t;

endpackage : tpm_pkg

// >>> tpm_presc_if.sv
`timescale 1ns/1ps
`default_nettype none

// Prescaler control and tick between timer core and divider
interface tpm_presc_if;
    logic       enable;
    logic [2:0] clock_divide_exponent;
    logic       tick;

    modport ctl (output enable, output clock_divide_exponent, input tick);
    modport div (input enable, input clock_divide_exponent, output tick);
endinterface : tpm_presc_if

`default_nettype wire

// >>> tpm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module tpm_prescaler (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    tpm_presc_if.div  pif
);

    // ********************************************************
    // Divider
    // ********************************************************
    logic [6:0] cnt;
    logic [7:0] mask8;
    logic [6:0] mask;

    // Low exponent bits of the count all ones marks a tick
    assign mask8 = (8'h01 << pif.clock_divide_exponent) - 8'h01;
    assign mask  = mask8[6:0];
    assign pif.tick = pif.enable && ((cnt & mask) == mask); // [R9]

    // Free count, cleared while the timer is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 7'h00;
        end else if (ce) begin
            if (!pif.enable) begin
                cnt <= 7'h00; // [R10]
            end else begin
                cnt <= cnt + 7'h01; // [R9]
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_presc_clear;
        @(posedge hclk) disable iff (!hresetn)
        ce && !pif.enable |=> cnt == 7'h00;
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared"); // [R10]

    property p_presc_spacing;
        @(posedge hclk) disable iff (!hresetn)
        ce && pif.enable && pif.tick && pif.clock_divide_exponent != 3'h0
            |=> !pif.tick || pif.clock_divide_exponent == 3'h0;
    endproperty
    a_presc_spacing: assert property (p_presc_spacing) else $error("ticks too close"); // [R9]

endmodule : tpm_prescaler

`default_nettype wire

// >>> tpm_timer_top.sv
// Behaviour
// (R1) Toggle modes: output equals polarity when disabled
// (R2) Toggle modes: output inverts on each reload
// (R3) Counter mode counts on polarity-selected input edge
// (R4) PWM polarity 0: low idle, high match
// (R5) PWM polarity 1: high idle, low match
// (R6) Capture mode latches count on selected edge
// (R7) Gated: count at active level, event opposite
// (R8) Capture/compare: first edge starts, later capture
// (R9) Prescaler divides by two to exponent
// (R10) Prescaler cleared whenever timer disabled
// (R11) Mode code joins two control registers
// (R12) Codes 0000-0111 select the basic modes
// (R13) Codes 1000-1100 select the extended modes; none is implemented here, count and output hold while enabled
// (R14) Codes 1101-1111 are reserved, software avoids
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tpm_timer_top #(
    parameter int CW = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        timer_in,
    output logic             timer_out
);

    // Refuse counter widths the register bus cannot carry
    if (CW < 2 || CW > 32) begin : g_cw_check
        $error("CW must lie in 2..32");
    end

    // ********************************************************
    // Control state
    // ********************************************************
    logic                timer_enable;
    logic                io_polarity_select;
    logic [2:0]          clock_divide_exponent;
    logic [2:0]          mode_low;
    logic                mode_top;
    logic [CW-1:0]       reload_value;
    logic [CW-1:0]       match_value;
    logic [CW-1:0]       count;
    logic [CW-1:0]       capture_value;
    logic                started;
    logic                flag_reload;
    logic                flag_capture;
    logic                flag_gate;
    tpm_pkg::tpm_mode_t  operating_mode_code;

    // Mode code from both control registers
    assign operating_mode_code = tpm_pkg::tpm_mode_t'({mode_top, mode_low}); // [R11]

    // ********************************************************
    // AHB-Lite slave
    // ********************************************************
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       addr_ok;
    logic       wr_ctl1;
    logic [31:0] next_rdata;

    // Never waits except while frozen; always OKAY
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && hready && htrans[1];
    assign wr_ctl1   = wr_pend && (wr_addr == tpm_pkg::OFS_CTL1);

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (ce) begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (haddr[7:0])
            tpm_pkg::OFS_CTL1: begin
                next_rdata[tpm_pkg::CTL1_EN_BIT]  = timer_enable;
                next_rdata[tpm_pkg::CTL1_POL_BIT] = io_polarity_select;
                next_rdata[tpm_pkg::CTL1_PRE_LSB +: 3]  = clock_divide_exponent;
                next_rdata[tpm_pkg::CTL1_MODE_LSB +: 3] = mode_low;
            end
            tpm_pkg::OFS_CTL0:    next_rdata[tpm_pkg::CTL0_MODE3_BIT] = mode_top;
            tpm_pkg::OFS_RELOAD:  next_rdata = 32'(reload_value);
            tpm_pkg::OFS_MATCH:   next_rdata = 32'(match_value);
            tpm_pkg::OFS_COUNT:   next_rdata = 32'(count);
            tpm_pkg::OFS_CAPTURE: next_rdata = 32'(capture_value);
            tpm_pkg::OFS_STATUS: begin
                next_rdata[tpm_pkg::STAT_RELOAD_BIT]  = flag_reload;
                next_rdata[tpm_pkg::STAT_CAPTURE_BIT] = flag_capture;
                next_rdata[tpm_pkg::STAT_GATE_BIT]    = flag_gate;
                next_rdata[tpm_pkg::STAT_OUT_BIT]     = timer_out;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce && addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ********************************************************
    // Input pin synchroniser and edges
    // ********************************************************
    logic in_meta;
    logic in_sync;
    logic in_prev;
    logic rise;
    logic fall;
    logic active_edge;
    logic passive_edge;
    logic level_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
            in_prev <= 1'b0;
        end else if (ce) begin
            in_meta <= timer_in;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end

    // Polarity picks the working edge and gate level
    assign rise         = in_sync && !in_prev;
    assign fall         = !in_sync && in_prev;
    assign active_edge  = io_polarity_select ? fall : rise; // [R3] [R6] [R8]
    assign passive_edge = io_polarity_select ? rise : fall; // [R7]
    assign level_active = in_sync ^ io_polarity_select; // [R7]

    // ********************************************************
    // Prescaler
    // ********************************************************
    tpm_presc_if pif ();

    assign pif.enable = timer_enable; // [R10]
    assign pif.clock_divide_exponent = clock_divide_exponent;

    tpm_prescaler u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pif     (pif)
    );

    // ********************************************************
    // Mode decode and counting events
    // ********************************************************
    logic advance;
    logic hit;
    logic match;
    logic toggle_mode;
    logic cap_event;

    // Extended and reserved modes do not count here
    always_comb begin
        advance     = 1'b0;
        toggle_mode = 1'b0;
        unique case (operating_mode_code)
            tpm_pkg::MODE_ONE_SHOT, tpm_pkg::MODE_CONTINUOUS: begin // [R12]
                advance     = pif.tick;
                toggle_mode = 1'b1;
            end
            tpm_pkg::MODE_COUNTER: begin
                advance     = active_edge; // [R3]
                toggle_mode = 1'b1;
            end
            tpm_pkg::MODE_COMPARE: begin
                advance     = pif.tick;
                toggle_mode = 1'b1;
            end
            tpm_pkg::MODE_PWM_SINGLE, tpm_pkg::MODE_CAPTURE: advance = pif.tick;
            tpm_pkg::MODE_GATED:   advance = pif.tick && level_active; // [R7]
            tpm_pkg::MODE_CAP_CMP: advance = pif.tick && started; // [R8]
            tpm_pkg::MODE_PWM_DUAL, tpm_pkg::MODE_CAP_RESTART,
            tpm_pkg::MODE_CMP_COUNTER, tpm_pkg::MODE_TRIG_ONE,
            tpm_pkg::MODE_DEMOD: advance = 1'b0; // [R13]
            tpm_pkg::MODE_RSVD_D, tpm_pkg::MODE_RSVD_E,
            tpm_pkg::MODE_RSVD_F: advance = 1'b0; // [R14]
        endcase
    end

    assign hit   = timer_enable && advance && (count == reload_value);
    assign match = timer_enable && advance && (count == match_value);
    assign cap_event = timer_enable && active_edge
                       && ((operating_mode_code == tpm_pkg::MODE_CAPTURE)
                           || (operating_mode_code == tpm_pkg::MODE_CAP_CMP && started));

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_enable          <= tpm_pkg::CTL1_RESET[tpm_pkg::CTL1_EN_BIT];
            io_polarity_select    <= tpm_pkg::CTL1_RESET[tpm_pkg::CTL1_POL_BIT];
            clock_divide_exponent <= tpm_pkg::CTL1_RESET[tpm_pkg::CTL1_PRE_LSB +: 3];
            mode_low              <= tpm_pkg::CTL1_RESET[tpm_pkg::CTL1_MODE_LSB +: 3];
        end else if (ce) begin
            if (wr_ctl1) begin
                timer_enable          <= hwdata[tpm_pkg::CTL1_EN_BIT];
                io_polarity_select    <= hwdata[tpm_pkg::CTL1_POL_BIT];
                clock_divide_exponent <= hwdata[tpm_pkg::CTL1_PRE_LSB +: 3];
                mode_low              <= hwdata[tpm_pkg::CTL1_MODE_LSB +: 3]; // [R11]
            end else if (hit && operating_mode_code == tpm_pkg::MODE_ONE_SHOT) begin
                timer_enable <= 1'b0; // One-shot stops after its reload
            end
        end
    end

    // Top mode bit, reload and PWM match words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_top     <= tpm_pkg::CTL0_RESET[tpm_pkg::CTL0_MODE3_BIT];
            reload_value <= tpm_pkg::RELOAD_RESET[CW-1:0];
            match_value  <= tpm_pkg::MATCH_RESET[CW-1:0];
        end else if (ce && wr_pend) begin
            if (wr_addr == tpm_pkg::OFS_CTL0) begin
                mode_top <= hwdata[tpm_pkg::CTL0_MODE3_BIT]; // [R11]
            end
            if (wr_addr == tpm_pkg::OFS_RELOAD) begin
                reload_value <= hwdata[CW-1:0];
            end
            if (wr_addr == tpm_pkg::OFS_MATCH) begin
                match_value <= hwdata[CW-1:0];
            end
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reload  <= 1'b0;
            flag_capture <= 1'b0;
            flag_gate    <= 1'b0;
        end else if (ce) begin
            flag_reload  <= hit || (flag_reload && !(wr_pend && wr_addr == tpm_pkg::OFS_STATUS
                                    && hwdata[tpm_pkg::STAT_RELOAD_BIT]));
            flag_capture <= cap_event || (flag_capture && !(wr_pend
                                    && wr_addr == tpm_pkg::OFS_STATUS
                                    && hwdata[tpm_pkg::STAT_CAPTURE_BIT]));
            flag_gate    <= (timer_enable && operating_mode_code == tpm_pkg::MODE_GATED
                             && passive_edge) // [R7]
                            || (flag_gate && !(wr_pend && wr_addr == tpm_pkg::OFS_STATUS
                                    && hwdata[tpm_pkg::STAT_GATE_BIT]));
        end
    end

    // ********************************************************
    // Counter, start flag and capture
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count   <= '0;
            started <= 1'b0;
        end else if (ce) begin
            if (!timer_enable) begin
                count   <= '0;
                started <= 1'b0;
            end else begin
                if (operating_mode_code == tpm_pkg::MODE_CAP_CMP && active_edge) begin
                    started <= 1'b1; // [R8]
                end
                if (hit && operating_mode_code != tpm_pkg::MODE_COMPARE) begin
                    count <= '0;
                end else if (advance) begin
                    count <= count + 1'b1; // [R3]
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_value <= '0;
        end else if (ce && cap_event) begin
            capture_value <= count; // [R6] [R8]
        end
    end

    // ********************************************************
    // Timer output
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_out <= 1'b0;
        end else if (ce) begin
            if (!timer_enable) begin
                timer_out <= io_polarity_select; // [R1] [R4] [R5]
            end else if (operating_mode_code == tpm_pkg::MODE_PWM_SINGLE) begin
                if (hit) begin
                    timer_out <= io_polarity_select; // [R4] [R5]
                end else if (match) begin
                    timer_out <= !io_polarity_select; // [R4] [R5]
                end
            end else if (toggle_mode && hit) begin
                timer_out <= !timer_out; // [R2]
            end
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_idle_level;
        @(posedge hclk) disable iff (!hresetn)
        ce && !timer_enable |=> timer_out == $past(io_polarity_select);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // [R1]

    property p_reload_toggle;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && toggle_mode && hit |=> timer_out != $past(timer_out);
    endproperty
    a_reload_toggle: assert property (p_reload_toggle) else $error("no toggle on reload"); // [R2]

    property p_counter_edge;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_COUNTER && !wr_pend
            && !active_edge |=> count == $past(count);
    endproperty
    a_counter_edge: assert property (p_counter_edge) else $error("count off edge"); // [R3]

    property p_pwm_low;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_PWM_SINGLE
            && !io_polarity_select && match && !hit |=> timer_out;
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("pwm match level wrong"); // [R4]

    property p_pwm_high;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_PWM_SINGLE
            && io_polarity_select && hit |=> !$past(hit) || timer_out;
    endproperty
    a_pwm_high: assert property (p_pwm_high) else $error("pwm reload level wrong"); // [R5]

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_CAPTURE && active_edge
            |=> capture_value == $past(count) && flag_capture;
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed"); // [R6]

    property p_gate_hold;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_GATED
            && !level_active |=> count == $past(count);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("counted outside gate"); // [R7]

    property p_wait_start;
        @(posedge hclk) disable iff (!hresetn)
        ce && timer_enable && operating_mode_code == tpm_pkg::MODE_CAP_CMP && !started
            |=> count == $past(count);
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("counted before start"); // [R8]

    property p_mode_write;
        @(posedge hclk) disable iff (!hresetn)
        ce && wr_ctl1 |=> operating_mode_code[2:0] == $past(hwdata[2:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bits not stored"); // [R11]

endmodule : tpm_timer_top

`default_nettype wire

// >>> tpm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Signal source on the timer input and load on the timer output
module tpm_pin_model (
    input  wire logic hclk,
    input  wire logic drive_level,
    input  wire logic timer_out,
    output logic      timer_in,
    output int        toggles
);
    // Source changes the pin just after the clock edge
    always_ff @(posedge hclk) begin
        timer_in <= drive_level;
    end

    // Load counts every change of the output level
    initial toggles = 0;
    always @(timer_out) toggles = toggles + 1;
endmodule : tpm_pin_model

`default_nettype wire

// >>> timer_polarity_prescale_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module timer_polarity_prescale_mode_control_tb_top;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        lvl     = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic        hreadyout;
    logic        hresp;
    logic        timer_in;
    logic        timer_out;
    int          error_cnt = 0;
    int          compares  = 0;
    int          n;
    int          t;
    // Ordinary cases: control value, expected idle output
    logic [8:0]  idle_rows [6] = '{{8'h40, 1'b1}, {8'h03, 1'b0}, {8'h43, 1'b1},
                                   {8'h45, 1'b1}, {8'h42, 1'b1}, {8'h01, 1'b0}};
    // Input event cases: control value, idle pin level, status bit
    logic [11:0] ev_rows [4] = '{{8'h84, 1'b1, 3'd1}, {8'hc4, 1'b0, 3'd1},
                                 {8'h86, 1'b0, 3'd2}, {8'hc6, 1'b1, 3'd2}};

    always #10 hclk = ~hclk;

    tpm_timer_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .timer_in(timer_in), .timer_out(timer_out));

    tpm_pin_model pm (.hclk(hclk), .drive_level(lvl), .timer_out(timer_out),
        .timer_in(timer_in), .toggles(t));

    // ********************************************************
    // Bus and check tasks
    // ********************************************************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        compares++;
        if (a !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: expected %h, got %h", $time, e, a);
        end
    endtask : chk

    // Cycles until the output next changes
    task automatic gap(output int c);
        logic v;
        v = timer_out;
        c = 0;
        while (timer_out === v && c < 2000) begin
            @(negedge hclk);
            c++;
        end
    endtask : gap

    // Pin level, then time for the synchroniser
    task automatic pin(input logic v);
        lvl <= v;
        repeat (6) @(posedge hclk);
    endtask : pin

    task automatic conclude;
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(tpm_pkg::OFS_CTL1, q);
        chk(32'(tpm_pkg::CTL1_RESET), q);
        chk(32'h0, 32'(timer_out));
        rd(tpm_pkg::OFS_RELOAD, q);
        chk(tpm_pkg::RELOAD_RESET, q);
        rd(8'h1c, q);
        chk(32'h0, q | 32'(hresp));
        foreach (idle_rows[i]) begin
            wr(tpm_pkg::OFS_CTL1, 32'(idle_rows[i][8:1]));
            repeat (2) @(negedge hclk);
            chk(32'(idle_rows[i][0]), 32'(timer_out));
        end
        // Reload every third tick, all divide codes
        wr(tpm_pkg::OFS_RELOAD, 32'h2);
        for (int e = 0; e < 8; e++) begin
            wr(tpm_pkg::OFS_CTL1, 32'h0);
            wr(tpm_pkg::OFS_CTL1, 32'h81 | (e << 3));
            gap(n);
            gap(n);
            chk(32'(3 << e), 32'(n));
        end
        // Top mode bit makes code 9, which stays quiet; 13-15 never written
        wr(tpm_pkg::OFS_CTL0, 32'h80);
        wr(tpm_pkg::OFS_CTL1, 32'h81);
        n = t;
        repeat (40) @(negedge hclk);
        chk(32'(n), 32'(t));
        wr(tpm_pkg::OFS_CTL0, 32'h0);
        gap(n);
        gap(n);
        chk(32'h3, 32'(n));
        // Edge counting in both polarities
        wr(tpm_pkg::OFS_RELOAD, 32'hffff);
        for (int p = 0; p < 2; p++) begin
            wr(tpm_pkg::OFS_CTL1, 32'h0);
            pin(p[0]);
            wr(tpm_pkg::OFS_CTL1, 32'h82 | (p << 6));
            repeat (3) begin
                pin(~p[0]);
                pin(p[0]);
            end
            rd(tpm_pkg::OFS_COUNT, q);
            chk(32'h3, q);
        end
        // Capture rows: passive edge first, active edge second; gated rows: active edge first, passive edge second
        foreach (ev_rows[i]) begin
            wr(tpm_pkg::OFS_CTL1, 32'h0);
            pin(ev_rows[i][3]);
            wr(tpm_pkg::OFS_CTL1, 32'(ev_rows[i][11:4]));
            wr(tpm_pkg::OFS_STATUS, 32'h7);
            pin(~ev_rows[i][3]);
            rd(tpm_pkg::OFS_STATUS, q);
            chk(32'h0, 32'(q[ev_rows[i][2:0]]));
            pin(ev_rows[i][3]);
            rd(tpm_pkg::OFS_STATUS, q);
            chk(32'h1, 32'(q[ev_rows[i][2:0]]));
        end
        // Capture/compare waits for its first rising edge, then captures a count of 11 at the next rising edge, 12 ticks later
        wr(tpm_pkg::OFS_CTL1, 32'h0);
        pin(1'b0);
        wr(tpm_pkg::OFS_CTL1, 32'h87);
        rd(tpm_pkg::OFS_COUNT, q);
        chk(32'h0, q);
        pin(1'b1);
        pin(1'b0);
        pin(1'b1);
        rd(tpm_pkg::OFS_CAPTURE, q);
        chk(32'hb, q);
        // Single-output PWM: match level lasts 3 of 4 ticks
        wr(tpm_pkg::OFS_RELOAD, 32'h3);
        wr(tpm_pkg::OFS_MATCH, 32'h0);
        for (int p = 0; p < 2; p++) begin
            wr(tpm_pkg::OFS_CTL1, 32'(p << 6));
            wr(tpm_pkg::OFS_CTL1, 32'h83 | (p << 6));
            gap(n);
            gap(n);
            chk(32'h3, 32'(n));
            chk(32'(p), 32'(timer_out));
        end
        // One-shot switches itself off at its reload
        wr(tpm_pkg::OFS_CTL1, 32'h0);
        wr(tpm_pkg::OFS_STATUS, 32'h7);
        wr(tpm_pkg::OFS_CTL1, 32'h80);
        repeat (8) @(posedge hclk);
        rd(tpm_pkg::OFS_CTL1, q);
        chk(32'h0, q);
        rd(tpm_pkg::OFS_STATUS, q);
        chk(32'h1, q);
        conclude;
    end

    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        error_cnt++;
        conclude;
    end
endmodule : timer_polarity_prescale_mode_control_tb_top

`default_nettype wire
